// *** rtl/acc_pkg.sv ***
package acc_pkg;

   // =====================================================================
   // Register map and field positions.
   // =====================================================================
   // Register indices step by one, so the byte address is 4 * index.
   localparam logic [11:0] CTL0_IDX = 12'hF70;
   localparam logic [11:0] CTL1_IDX = 12'hF71;
   localparam logic [11:0] DATH_IDX = 12'hF72;
   localparam logic [11:0] DATL_IDX = 12'hF73;
   localparam logic [13:0] CTL0_ADDR = {CTL0_IDX, 2'b00};
   localparam logic [13:0] CTL1_ADDR = {CTL1_IDX, 2'b00};
   localparam logic [13:0] DATH_ADDR = {DATH_IDX, 2'b00};
   localparam logic [13:0] DATL_ADDR = {DATL_IDX, 2'b00};

   localparam int GO_BIT = 7;
   localparam int REF_LO_BIT = 6;
   localparam int REF_PIN_BIT = 5;
   localparam int REPEAT_BIT = 4;
   localparam int REF_HI_BIT = 7;
   localparam int UP_ALM_EN_BIT = 4;
   localparam int LO_ALM_EN_BIT = 3;

   localparam logic [7:0] CTL0_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h80;

   // =====================================================================
   // Timing counts at the system clock.
   // =====================================================================
   localparam int SINGLE_CYC = 5129;
   localparam int REPEAT_CYC = 256;
   localparam int WAKE_CYC = 40;
   localparam int IDLE_CYC = 160;

   // =====================================================================
   // Decoded codes.
   // =====================================================================
   localparam logic [2:0] BUF_SE_RAW = 3'h0;
   localparam logic [2:0] BUF_SE_UNITY = 3'h1;
   localparam logic [2:0] BUF_DI_RAW = 3'h4;
   localparam logic [2:0] BUF_DI_UNITY = 3'h5;
   localparam logic [2:0] BUF_DI_GAIN20 = 3'h7;
   localparam logic [3:0] SEL_SE_LAST_PIN = 4'h7;
   localparam logic [3:0] SEL_SE_TIA_GND = 4'hC;
   localparam logic [3:0] SEL_SE_TEMP = 4'hE;
   localparam logic [3:0] SEL_OFFSET_CAL = 4'hF;
   localparam logic [3:0] SEL_DI_LAST_PAIR = 4'hA;
   localparam int CAL_BYTES_PER_MODE = 3;
   localparam int CAL_MODES = 10;
   localparam int CAL_TOTAL_BYTES = CAL_BYTES_PER_MODE * CAL_MODES;

   typedef enum logic [3:0] {
      ACC_IDLE = 4'b0001,
      ACC_WAKE = 4'b0010,
      ACC_FIRST = 4'b0100,
      ACC_REPEAT = 4'b1000
   } acc_state_t;

   // Switch and reference controls toward the analog core.
   typedef struct packed {
      logic [7:0] pin_sw_p;
      logic [7:0] pin_sw_n;
      logic tia_ground;
      logic temp_sel;
      logic offset_short;
      logic diff_mode;
      logic buffered;
      logic gain20;
      logic ref_int_en;
      logic ref_2v0;
      logic ref_out_en;
      logic powered;
      logic sample_go;
   } acc_analog_t;

endpackage : acc_pkg

// *** rtl/acc_conv_ctrl.sv ***
`timescale 1ns/1ps
// What this block does
// - A one written to conversion_go starts a conversion on the input.
// - A one written mid-conversion abandons it and restarts the count.
// - Go bit reads one until the end clears it; zero writes are ignored.
// - Reference level 00 external, 01 is 1.0 V, 10 is 2.0 V, 11 reserved.
// - ref_to_pin zero frees the pin; one buffers the internal reference out at levels 01 and 10 only.
// - Single-shot mode delivers one result after 5129 clock cycles.
// - Continuous mode updates the result every 256 clock cycles.
// - input_select meaning follows the single-ended or differential mode.
// - Single-ended: 0-7 pins, C grounds amp nodes, E temperature, F offset.
// - Differential: 0-A fixed pairs, B-E reserved, F offset calibration.
// - Reserved input codes open every input switch.
// - Offset calibration shorts the two converter inputs together.
// - Calibration data: 30 bytes, three per mode, offset then two gain.
// - Buffer modes 000,001,100,101,111 decoded; others reserved.
// - A start from power-down first spends 40 cycles powering up.
// - Converter powers down after 160 consecutive idle cycles.
// - Each result stores 11-bit value; done pulse when both alarms off.
module acc_conv_ctrl #(
   parameter int SINGLE_CYCLES = acc_pkg::SINGLE_CYC,
   parameter int REPEAT_CYCLES = acc_pkg::REPEAT_CYC
) (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic [13:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [10:0] i_core_result,
   output acc_pkg::acc_analog_t o_analog,
   output logic [10:0] o_result,
   output logic o_conv_done
);

   localparam int CW = 13;

   // ====================================================================
   // Register state.
   // ====================================================================
   logic [7:0] ctl0_r, ctl0_nxt;
   logic [7:0] ctl1_r, ctl1_nxt;
   logic [10:0] res_r, res_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic done_r, done_nxt;
   acc_pkg::acc_state_t st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [7:0] idle_r, idle_nxt;
   logic pwr_r, pwr_nxt;
   acc_pkg::acc_analog_t ana_r, ana_nxt;

   logic go_wr;
   logic finish;
   logic alarms_off;

   assign go_wr = i_wr && i_addr == acc_pkg::CTL0_ADDR
                  && i_wdata[acc_pkg::GO_BIT];
   assign alarms_off = !ctl1_r[acc_pkg::UP_ALM_EN_BIT]
                       && !ctl1_r[acc_pkg::LO_ALM_EN_BIT];

   // ====================================================================
   // Conversion sequencer.
   // ====================================================================
   // A start write always reloads the count, so a restart is clean.
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      idle_nxt = idle_r;
      pwr_nxt = pwr_r;
      finish = 1'b0;
      unique case (st_r)
         acc_pkg::ACC_IDLE: begin
            if (pwr_r) begin
               if (idle_r == 8'(acc_pkg::IDLE_CYC - 1)) begin
                  pwr_nxt = 1'b0;
               end else begin
                  idle_nxt = idle_r + 8'h01;
               end
            end
         end
         acc_pkg::ACC_WAKE: begin
            if (cnt_r == CW'(acc_pkg::WAKE_CYC - 1)) begin
               st_nxt = acc_pkg::ACC_FIRST;
               cnt_nxt = '0;
               pwr_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
         acc_pkg::ACC_FIRST: begin
            if (cnt_r == CW'(SINGLE_CYCLES - 1)) begin
               finish = 1'b1;
               cnt_nxt = '0;
               idle_nxt = '0;
               st_nxt = ctl0_r[acc_pkg::REPEAT_BIT] ? acc_pkg::ACC_REPEAT
                                                     : acc_pkg::ACC_IDLE;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
         acc_pkg::ACC_REPEAT: begin
            if (!ctl0_r[acc_pkg::REPEAT_BIT]) begin
               st_nxt = acc_pkg::ACC_IDLE;
               idle_nxt = '0;
            end else if (cnt_r == CW'(REPEAT_CYCLES - 1)) begin
               finish = 1'b1;
               cnt_nxt = '0;
            end else begin
               cnt_nxt = cnt_r + CW'(1);
            end
         end
      endcase
      if (go_wr) begin
         cnt_nxt = '0;
         idle_nxt = '0;
         st_nxt = pwr_r ? acc_pkg::ACC_FIRST : acc_pkg::ACC_WAKE;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         st_r <= acc_pkg::ACC_IDLE;
         cnt_r <= '0;
         idle_r <= '0;
         pwr_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         idle_r <= idle_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   // ====================================================================
   // Register file, result capture and read port.
   // ====================================================================
   // Unmapped reads return zero; the data registers are read-only.
   always_comb begin
      ctl0_nxt = ctl0_r;
      ctl1_nxt = ctl1_r;
      res_nxt = res_r;
      done_nxt = 1'b0;
      rdata_nxt = 8'h00;
      if (i_wr && i_addr == acc_pkg::CTL0_ADDR) begin
         // Zero writes leave the go bit alone.
         ctl0_nxt = {ctl0_r[acc_pkg::GO_BIT] | i_wdata[acc_pkg::GO_BIT],
                     i_wdata[6:0]};
      end
      if (i_wr && i_addr == acc_pkg::CTL1_ADDR) begin
         ctl1_nxt = i_wdata;
      end
      if (finish && !go_wr) begin
         ctl0_nxt[acc_pkg::GO_BIT] = 1'b0;
      end
      if (finish) begin
         res_nxt = i_core_result;
         done_nxt = alarms_off;
      end
      if (i_rd) begin
         unique case (i_addr)
            acc_pkg::CTL0_ADDR: rdata_nxt = ctl0_r;
            acc_pkg::CTL1_ADDR: rdata_nxt = ctl1_r;
            acc_pkg::DATH_ADDR: rdata_nxt = res_r[10:3];
            acc_pkg::DATL_ADDR: rdata_nxt = {res_r[2:0], 5'h00};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ctl0_r <= acc_pkg::CTL0_RST;
         ctl1_r <= acc_pkg::CTL1_RST;
         res_r <= '0;
         done_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         ctl0_r <= ctl0_nxt;
         ctl1_r <= ctl1_nxt;
         res_r <= res_nxt;
         done_r <= done_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ====================================================================
   // Analog switch and reference decode.
   // ====================================================================
   // Decoding from the stored fields keeps the switches steady between
   // writes; a reserved code leaves every switch open.
   always_comb begin
      logic [3:0] sel;
      logic [2:0] bm;
      logic [1:0] refl;
      logic se;
      logic di;
      logic [2:0] pos;
      logic [2:0] neg;
      sel = ctl0_r[3:0];
      pos = 3'h0;
      neg = 3'h0;
      bm = ctl1_r[2:0];
      refl = {ctl1_r[acc_pkg::REF_HI_BIT], ctl0_r[acc_pkg::REF_LO_BIT]};
      ana_nxt = '0;
      se = bm == acc_pkg::BUF_SE_RAW || bm == acc_pkg::BUF_SE_UNITY;
      di = bm == acc_pkg::BUF_DI_RAW || bm == acc_pkg::BUF_DI_UNITY
           || bm == acc_pkg::BUF_DI_GAIN20;
      ana_nxt.diff_mode = di;
      ana_nxt.buffered = bm[0] && (se || di);
      ana_nxt.gain20 = bm == acc_pkg::BUF_DI_GAIN20;
      if (se) begin
         if (sel <= acc_pkg::SEL_SE_LAST_PIN) begin
            ana_nxt.pin_sw_p[sel[2:0]] = 1'b1;
         end else if (sel == acc_pkg::SEL_SE_TIA_GND) begin
            ana_nxt.tia_ground = 1'b1;
         end else if (sel == acc_pkg::SEL_SE_TEMP) begin
            ana_nxt.temp_sel = 1'b1;
         end else if (sel == acc_pkg::SEL_OFFSET_CAL) begin
            ana_nxt.offset_short = 1'b1;
         end
      end else if (di) begin
         if (sel == acc_pkg::SEL_OFFSET_CAL) begin
            ana_nxt.offset_short = 1'b1;
         end else if (sel <= acc_pkg::SEL_DI_LAST_PAIR) begin
            // Pair table: non-inverting pin in the upper three bits.
            unique case (sel)
               4'h0: {pos, neg} = 6'h01;
               4'h1: {pos, neg} = 6'h13;
               4'h2: {pos, neg} = 6'h25;
               4'h3: {pos, neg} = 6'h08;
               4'h4: {pos, neg} = 6'h1A;
               4'h5: {pos, neg} = 6'h2C;
               4'h6: {pos, neg} = 6'h35;
               4'h7: {pos, neg} = 6'h02;
               4'h8: {pos, neg} = 6'h03;
               4'h9: {pos, neg} = 6'h04;
               default: {pos, neg} = 6'h05;
            endcase
            ana_nxt.pin_sw_p[pos] = 1'b1;
            ana_nxt.pin_sw_n[neg] = 1'b1;
         end
      end
      ana_nxt.ref_int_en = refl == 2'b01 || refl == 2'b10;
      ana_nxt.ref_2v0 = refl == 2'b10;
      ana_nxt.ref_out_en = ctl0_r[acc_pkg::REF_PIN_BIT]
                           && ana_nxt.ref_int_en;
      ana_nxt.powered = pwr_nxt || st_nxt == acc_pkg::ACC_WAKE;
      ana_nxt.sample_go = st_nxt == acc_pkg::ACC_FIRST
                          || st_nxt == acc_pkg::ACC_REPEAT;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ana_r <= '0;
      end else begin
         ana_r <= ana_nxt;
      end
   end

   assign o_analog = ana_r;
   assign o_result = res_r;
   assign o_conv_done = done_r;
   assign o_rdata = rdata_r;

   // ====================================================================
   // Checks.
   // ====================================================================
   a_zero_write_kept: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      i_wr && i_addr == acc_pkg::CTL0_ADDR && ctl0_r[7] && !finish
      |=> ctl0_r[7]) else $error("go bit lost on write");
   a_go_sets_bit: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      go_wr |=> ctl0_r[7]) else $error("start write not seen");
   a_restart_count: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      go_wr |=> cnt_r == '0) else $error("restart did not reload");
   a_done_clears_go: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      finish && !go_wr && st_r == acc_pkg::ACC_FIRST |=> !ctl0_r[7])
      else $error("go bit not cleared");
   a_wake_length: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(st_r == acc_pkg::ACC_WAKE) && !go_wr |-> ##39
      (st_r == acc_pkg::ACC_WAKE || go_wr)) else $error("short wake");
   a_done_gated: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_conv_done |-> $past(alarms_off)) else $error("done with alarm");
   a_result_load: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      finish |=> o_result == $past(i_core_result))
      else $error("result not stored");
   a_repeat_period: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      finish && st_r == acc_pkg::ACC_REPEAT |-> ##1 !finish [*8])
      else $error("repeat too fast");
   a_short_only_cal: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      o_analog.offset_short |-> o_analog.pin_sw_p == '0)
      else $error("pins with short");
   // Reserved buffer mode 010 must leave the pin, temperature and offset switches open.
   a_reserved_open: assert property (
      @(posedge i_mclk) disable iff (i_sys_rst)
      ctl1_r[2:0] == 3'h2 |=> o_analog.pin_sw_p == '0
      && o_analog.pin_sw_n == '0 && !o_analog.temp_sel
      && !o_analog.offset_short) else $error("reserved mode closed a switch");
   c_single: cover property (@(posedge i_mclk) finish
      && st_r == acc_pkg::ACC_FIRST);
   c_repeat: cover property (@(posedge i_mclk) finish
      && st_r == acc_pkg::ACC_REPEAT);
   c_restart: cover property (@(posedge i_mclk) go_wr && ctl0_r[7]);
   c_sleep: cover property (@(posedge i_mclk) $fell(pwr_r));

endmodule : acc_conv_ctrl

// *** tb/acc_core_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// Converter core stand-in.
// =====================================================================
module acc_core_model (
   input wire logic i_mclk,
   input wire acc_pkg::acc_analog_t i_analog,
   input wire logic [10:0] i_level,
   output logic [10:0] o_core_result
);
   logic [10:0] junk_r = 11'h2A5;
   // An unpowered core shows a wandering value, so a stale sample is caught.
   always @(posedge i_mclk) begin
      junk_r <= ~junk_r + 11'h013;
   end
   assign o_core_result = i_analog.powered ? i_level : junk_r;
endmodule : acc_core_model

// *** tb/acc_conv_ctrl_bench.sv ***
`timescale 1ns/1ps
module acc_conv_ctrl_bench;
   localparam int SGL = 20;
   localparam int RPT = 10;
   logic i_mclk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [13:0] i_addr = 14'h0000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic [10:0] core_res;
   acc_pkg::acc_analog_t o_analog;
   logic [10:0] o_result;
   logic o_conv_done;
   logic [10:0] level = 11'h000;
   logic [31:0] lfsr = 32'hAB31B817;
   logic rd_d = 1'b0;
   logic [18:0] ex;
   int bad_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0;
   logic [7:0] rd_q[$];
   logic [10:0] res_q[$];

   // =====================================================================
   // Clock, design and core model.
   // =====================================================================
   always #2 i_mclk = ~i_mclk;
   acc_conv_ctrl #(.SINGLE_CYCLES(SGL), .REPEAT_CYCLES(RPT))
      acc_conv_ctrl_inst (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_core_result(core_res), .o_analog(o_analog), .o_result(o_result),
      .o_conv_done(o_conv_done));
   acc_core_model acc_core_model_inst (.i_mclk(i_mclk), .i_analog(o_analog),
      .i_level(level), .o_core_result(core_res));

   // =====================================================================
   // Shared helpers.
   // =====================================================================
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   // Expected {p switches, n switches, ground, temperature, offset short}.
   function automatic logic [18:0] exp_sw(input int m, input int c);
      int pp[11] = '{0, 2, 4, 1, 3, 5, 6, 0, 0, 0, 0};
      int nn[11] = '{1, 3, 5, 0, 2, 4, 5, 2, 3, 4, 5};
      logic [7:0] one = 8'h01;
      if (m == 0 || m == 1) begin
         if (c < 8) return {one << c, 8'h00, 3'h0};
         if (c == 12) return {16'h0000, 3'h4};
         if (c == 14) return {16'h0000, 3'h2};
      end else if (m == 4 || m == 5 || m == 7) begin
         if (c < 11) return {one << pp[c], one << nn[c], 3'h0};
      end
      if (c == 15 && m != 2 && m != 3 && m != 6) return {16'h0000, 3'h1};
      return 19'h00000;
   endfunction : exp_sw

   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check

   // Strobes drop one edge before the next request, never in the same step.
   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      @(posedge i_mclk);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(posedge i_mclk);
   endtask : rd

   task automatic wait_done(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_conv_done !== 1'b1 && n < lim);
   endtask : wait_done

   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : test_done

   // =====================================================================
   // Watcher: takes the oldest note whenever a result appears.
   // =====================================================================
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      rd_d <= i_rd;
      if (rd_d) begin
         check(rd_q.size() > 0 && o_rdata === rd_q.pop_front(),
            "read");
      end
      if (o_conv_done === 1'b1) begin
         check(res_q.size() > 0 && o_result === res_q.pop_front(),
            "res");
      end
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end

   // =====================================================================
   // Main sequence.
   // =====================================================================
   initial begin
      repeat (10) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      @(posedge i_mclk);
      rd(acc_pkg::CTL0_ADDR, 8'h00);
      rd(acc_pkg::CTL1_ADDR, 8'h80);
      rd(14'h0004, 8'h00);
      wr(acc_pkg::DATH_ADDR, 8'hFF);
      rd(acc_pkg::DATH_ADDR, 8'h00);
      $display("test reset values done");
      // Walk all four reference levels with the pin buffer requested.
      for (int r = 0; r < 4; r++) begin
         wr(acc_pkg::CTL1_ADDR, {r[1], 7'h01});
         wr(acc_pkg::CTL0_ADDR, {1'b0, r[0], 6'h20});
         rd(acc_pkg::CTL0_ADDR, {1'b0, r[0], 6'h20});
         check(o_analog.ref_int_en === (r == 1 || r == 2), "ref on");
         check(o_analog.ref_2v0 === (r == 2), "ref level");
         check(o_analog.ref_out_en === (r == 1 || r == 2), "ref pin");
      end
      wr(acc_pkg::CTL0_ADDR, 8'h00);
      @(posedge i_mclk);
      check(o_analog.ref_out_en === 1'b0, "ref pin off");
      $display("test reference done");
      // Every buffer mode against every input code.
      for (int m = 0; m < 8; m++) begin
         for (int c = 0; c < 16; c++) begin
            wr(acc_pkg::CTL1_ADDR, {5'h10, m[2:0]});
            wr(acc_pkg::CTL0_ADDR, {4'h0, c[3:0]});
            @(posedge i_mclk);
            ex = exp_sw(m, c);
            check({o_analog.pin_sw_p, o_analog.pin_sw_n} === ex[18:3],
               "switches");
            check({o_analog.tia_ground, o_analog.temp_sel,
               o_analog.offset_short} === ex[2:0], "special");
            check({o_analog.diff_mode, o_analog.buffered, o_analog.gain20}
               === {m == 4 || m == 5 || m == 7, m == 1 || m == 5 || m == 7,
               m == 7}, "buffer mode");
         end
      end
      $display("test input decode done");
      // Single shot from power-down, single-ended unity buffered input.
      wr(acc_pkg::CTL1_ADDR, 8'h81);
      check(o_analog.powered === 1'b0, "idle powered");
      lfsr = next_rand(lfsr);
      level <= lfsr[10:0];
      res_q.push_back(lfsr[10:0]);
      t0 = cyc;
      wr(acc_pkg::CTL0_ADDR, 8'h80);
      rd(acc_pkg::CTL0_ADDR, 8'h80);
      check(o_analog.powered === 1'b1 && o_analog.sample_go === 1'b0,
         "wake phase");
      wr(acc_pkg::CTL0_ADDR, 8'h00);
      rd(acc_pkg::CTL0_ADDR, 8'h80);
      wait_done(200);
      check(cyc - t0 >= 40 + SGL && cyc - t0 <= 44 + SGL, "wake");
      rd(acc_pkg::CTL0_ADDR, 8'h00);
      rd(acc_pkg::DATH_ADDR, lfsr[10:3]);
      rd(acc_pkg::DATL_ADDR, {lfsr[2:0], 5'h00});
      $display("test single shot done");
      // A second start mid-conversion begins the count again.
      wr(acc_pkg::CTL0_ADDR, 8'h80);
      repeat (8) @(posedge i_mclk);
      check(o_analog.sample_go === 1'b1, "sampling");
      lfsr = next_rand(lfsr);
      level <= lfsr[10:0];
      res_q.push_back(lfsr[10:0]);
      t0 = cyc;
      wr(acc_pkg::CTL0_ADDR, 8'h80);
      wait_done(100);
      check(cyc - t0 >= SGL && cyc - t0 <= SGL + 4, "restart");
      $display("test restart done");
      // Continuous mode, then alarm enable silences the done pulse.
      repeat (4) res_q.push_back(lfsr[10:0]);
      wr(acc_pkg::CTL0_ADDR, 8'h90);
      wait_done(100);
      rd(acc_pkg::CTL0_ADDR, 8'h10);
      for (int k = 0; k < 3; k++) begin
         t0 = cyc;
         wait_done(100);
         check(cyc - t0 == RPT || k == 0, "repeat period");
      end
      wr(acc_pkg::CTL1_ADDR, 8'h91);
      lfsr = next_rand(lfsr);
      level <= lfsr[10:0];
      repeat (3 * RPT) @(posedge i_mclk);
      rd(acc_pkg::DATH_ADDR, lfsr[10:3]);
      rd(acc_pkg::DATL_ADDR, {lfsr[2:0], 5'h00});
      t0 = cyc;
      wr(acc_pkg::CTL0_ADDR, 8'h00);
      while (o_analog.powered === 1'b1 && cyc - t0 < 300) @(posedge i_mclk);
      check(cyc - t0 >= 160 && cyc - t0 <= 166 + RPT, "idle off");
      check(res_q.size() == 0, "missing done");
      $display("test continuous done");
      check(acc_pkg::CAL_TOTAL_BYTES == 30, "calibration size");
      test_done();
   end
endmodule : acc_conv_ctrl_bench
